/* File: logic/rpx_if.sv */
// Two-wire bus joining the expander slave and the bus controller
`timescale 1ns/100ps
interface rpx_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  modport master (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n,
    input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface : rpx_if

/* File: logic/rpx_master.sv */
// Master end: APB-programmed byte-level I2C controller
`timescale 1ns/100ps
module rpx_master (
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  rpx_if.master bus // Two-wire bus
);
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_BIT = 2'b01,
    M_DONE = 2'b10
  } rpx_master_state_e;
  typedef struct packed {
    rpx_master_state_e st;
    logic [2:0] cmd;
    logic [15:0] div;
    logic [3:0] ph;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic nack;
    logic scl_lo;
    logic sda_lo;
    logic [1:0] sda_s;
    logic [31:0] rdat;
  } rpx_master_s;
  rpx_master_s m_q, m_d;
  logic acc, wr_cmd, tick;

  assign acc = psel && penable;
  assign wr_cmd = acc && pwrite && paddr == rpx_pkg::A_CMD && m_q.st == M_IDLE;
  assign tick = m_q.div == rpx_pkg::SCL_HALF;

  always_comb begin
    m_d = m_q;
    m_d.sda_s = {m_q.sda_s[0], bus.sda};
    m_d.div = tick ? 16'h0000 : m_q.div + 16'h0001;
    if (acc && pwrite && paddr == rpx_pkg::A_TXD) m_d.txd = pwdata[7:0];
    unique case (paddr)
      rpx_pkg::A_RXD: m_d.rdat = {24'h00_0000, m_q.rxd};
      rpx_pkg::A_STAT: m_d.rdat = {30'h0000_0000, m_q.nack, m_q.st != M_IDLE};
      default: m_d.rdat = 32'h0000_0000;
    endcase
    unique case (m_q.st)
      M_IDLE: if (wr_cmd) begin
        m_d.cmd = pwdata[2:0];
        m_d.ph = 4'h0;
        m_d.bitn = 4'h0;
        m_d.div = 16'h0000;
        m_d.sh = (pwdata[2:0] == rpx_pkg::C_WRITE) ? {m_q.txd, 1'b1}
            : {8'hFF, pwdata[2:0] == rpx_pkg::C_READ_ACK ? 1'b0 : 1'b1};
        m_d.st = M_BIT;
      end
      M_BIT: if (tick) begin
        m_d.ph = m_q.ph + 4'h1;
        unique case (m_q.cmd)
          rpx_pkg::C_START: begin
            unique case (m_q.ph)
              4'h0: begin m_d.sda_lo = 1'b0; m_d.scl_lo = 1'b0; end
              4'h1: m_d.sda_lo = 1'b1;
              default: begin m_d.scl_lo = 1'b1; m_d.st = M_DONE; end
            endcase
          end
          rpx_pkg::C_STOP: begin
            unique case (m_q.ph)
              4'h0: m_d.sda_lo = 1'b1;
              4'h1: m_d.scl_lo = 1'b0;
              default: begin m_d.sda_lo = 1'b0; m_d.st = M_DONE; end
            endcase
          end
          default: begin
            // Two ticks per bit: set data while low, then raise clock
            if (!m_q.ph[0]) begin
              m_d.scl_lo = 1'b1;
              m_d.sda_lo = !m_q.sh[8];
            end else begin
              m_d.scl_lo = 1'b0;
              m_d.sh = {m_q.sh[7:0], m_q.sda_s[1]};
            end
            if (m_q.ph[0] && m_q.bitn == 4'h8) begin
              m_d.st = M_DONE;
            end else if (m_q.ph[0]) begin
              m_d.bitn = m_q.bitn + 4'h1;
            end
          end
        endcase
      end
      M_DONE: if (tick) begin
        m_d.scl_lo = (m_q.cmd != rpx_pkg::C_STOP);
        if (m_q.cmd != rpx_pkg::C_STOP && m_q.cmd != rpx_pkg::C_START) begin
          m_d.sda_lo = 1'b0;
          m_d.nack = m_q.sh[0];
          m_d.rxd = m_q.sh[8:1];
        end
        m_d.st = M_IDLE;
      end
      default: m_d.st = M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      m_q <= '0;
      m_q.sda_s <= 2'b11;
      m_q.sh <= 9'h1FF;
    end else begin
      m_q <= m_d;
    end
  end

  assign prdata = m_q.rdat;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe_n = !m_q.scl_lo;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe_n = !m_q.sda_lo;
endmodule : rpx_master

/* File: logic/rpx_pkg.sv */
// Shared constants and the partner function for the register-pair I2C expander link
package rpx_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SCL_HZ = 100_000;
  localparam logic [15:0] SCL_HALF = 16'(CLK_HZ / (SCL_HZ * 2));
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h74;
  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_IN1 = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_POL0 = 3'h4;
  localparam logic [2:0] REG_CFG0 = 3'h6;
  localparam logic [7:0] OUT_RST = 8'hFF;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hFF;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] PTR_MASK = 3'h7;
  // APB register offsets of the controller
  localparam logic [11:0] A_CMD = 12'h000;
  localparam logic [11:0] A_TXD = 12'h004;
  localparam logic [11:0] A_RXD = 12'h008;
  localparam logic [11:0] A_STAT = 12'h00C;
  localparam logic [11:0] A_ADDR = 12'h010;
  // Command codes written to A_CMD
  localparam logic [2:0] C_START = 3'h1;
  localparam logic [2:0] C_WRITE = 3'h2;
  localparam logic [2:0] C_READ_ACK = 3'h3;
  localparam logic [2:0] C_READ_NACK = 3'h4;
  localparam logic [2:0] C_STOP = 3'h5;
  // Partner register of the same pair
  function automatic logic [2:0] partner(input logic [2:0] r);
    return {r[2:1], ~r[0]};
  endfunction : partner
endpackage : rpx_pkg

/* File: logic/rpx_slave.sv */
// Slave end: I2C register-pair expander core
// What this block does
// RQ1: Master writes address, command, then data
// RQ2: First byte loads pointer; data goes there
// RQ3: After each write pointer goes to partner
// RQ4: Unlimited write bytes alternate within pair
// RQ5: Pointed read: command, restart, address read
// RQ6: Read returns pointer register, then partner
// RQ7: Final read byte nacked; slave releases SDA
// RQ8: Pointer persists across start, points partner
// RQ9: Input captured at acknowledge clock rise
// RQ10: Read without command uses held pointer
// RQ11: Stop anytime; last acknowledged data valid
// RQ12: Power-on release resets registers and FSM
// RQ13: Power-off trip re-enters reset
// RQ14: Input pair read-only, shows pins
// RQ15: Output pair resets ones, reads stored
// RQ16: Polarity pair resets zero, inverts input
// RQ17: Config pair resets ones, 1 means input
// RQ18: Ack own address only, else ignore
//
// Design decisions made here: the placing of the registers.
`timescale 1ns/100ps
module rpx_slave (
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic power_on_release_level, // Supply above release level
  input wire logic power_off_trip_level, // Supply below trip level
  input wire logic [6:0] slave_addr, // Configured slave address
  input wire logic [15:0] port_in, // Port pin levels
  output logic [15:0] port_out, // Output register pair
  output logic [15:0] port_dir_in, // Config pair, 1 means input
  rpx_if.slave bus // Two-wire bus
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_CMD = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK = 3'b110
  } rpx_slave_state_e;
  typedef struct packed {
    rpx_slave_state_e st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic rd;
    logic got_cmd;
    logic [2:0] ptr;
    logic [15:0] in_reg;
    logic [15:0] out_reg;
    logic [15:0] pol_reg;
    logic [15:0] cfg_reg;
    logic drive_low;
    logic por_hold;
    logic full;
    logic [1:0] trip_s;
    logic [1:0] rel_s;
    logic [15:0] pin_s0;
    logic [15:0] pin_s1;
  } rpx_slave_s;
  rpx_slave_s s_q, s_d;
  logic scl_r, scl_f, start_c, stop_c, por_rst;

  function automatic logic [7:0] reg_rd(input rpx_slave_s s, input logic [2:0] r);
    logic [15:0] v;
    v = s.in_reg;
    unique case (r[2:1])
      2'd0: v = s.in_reg;
      2'd1: v = s.out_reg; // see RQ15
      2'd2: v = s.pol_reg;
      2'd3: v = s.cfg_reg;
    endcase
    return r[0] ? v[15:8] : v[7:0];
  endfunction : reg_rd

  assign scl_r = s_q.scl_s[1] && !s_q.scl_p;
  assign scl_f = !s_q.scl_s[1] && s_q.scl_p;
  assign start_c = s_q.scl_s[1] && s_q.scl_p && s_q.sda_p && !s_q.sda_s[1];
  assign stop_c = s_q.scl_s[1] && s_q.scl_p && !s_q.sda_p && s_q.sda_s[1];
  assign por_rst = rst || s_q.por_hold;

  always_comb begin
    s_d = s_q;
    s_d.scl_s = {s_q.scl_s[0], bus.scl};
    s_d.sda_s = {s_q.sda_s[0], bus.sda};
    s_d.scl_p = s_q.scl_s[1];
    s_d.sda_p = s_q.sda_s[1];
    // Supply levels and port pins are asynchronous: two flops each
    s_d.trip_s = {s_q.trip_s[0], power_off_trip_level};
    s_d.rel_s = {s_q.rel_s[0], power_on_release_level};
    s_d.pin_s0 = port_in;
    s_d.pin_s1 = s_q.pin_s0;
    if (s_q.trip_s[1]) begin
      s_d.por_hold = 1'b1; // see RQ13
    end else if (s_q.rel_s[1]) begin
      s_d.por_hold = 1'b0; // see RQ12
    end
    if (start_c) begin
      s_d.st = ST_ADDR; // see RQ8
      s_d.bitc = 3'h0;
      s_d.full = 1'b0;
      s_d.drive_low = 1'b0;
      s_d.got_cmd = 1'b0;
    end else if (stop_c) begin
      s_d.st = ST_IDLE; // see RQ11
      s_d.drive_low = 1'b0;
    end else begin
      unique case (s_q.st)
        ST_IDLE: s_d.drive_low = 1'b0; // see RQ18
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_r) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
            s_d.bitc = s_q.bitc + 3'h1;
            // Marks a whole byte, so the clock fall after a start is ignored
            s_d.full = (s_q.bitc == rpx_pkg::BIT_LAST);
          end
          if (scl_f && s_q.full) begin
            // Eighth bit shifted in: decide the acknowledge
            s_d.full = 1'b0;
            if (s_q.st == ST_ADDR) begin
              if (s_q.sh[7:1] == slave_addr) begin
                s_d.rd = s_q.sh[0];
                s_d.drive_low = 1'b1;
                s_d.st = ST_ACK;
              end else begin
                s_d.st = ST_IDLE; // see RQ18
              end
            end else if (s_q.st == ST_CMD) begin
              s_d.ptr = s_q.sh[2:0] & rpx_pkg::PTR_MASK; // see RQ2
              s_d.got_cmd = 1'b1;
              s_d.drive_low = 1'b1;
              s_d.st = ST_ACK;
            end else begin
              unique case (s_q.ptr[2:1])
                2'd0: ; // see RQ14
                2'd1: if (s_q.ptr[0]) s_d.out_reg[15:8] = s_q.sh;
                      else s_d.out_reg[7:0] = s_q.sh;
                2'd2: if (s_q.ptr[0]) s_d.pol_reg[15:8] = s_q.sh;
                      else s_d.pol_reg[7:0] = s_q.sh;
                2'd3: if (s_q.ptr[0]) s_d.cfg_reg[15:8] = s_q.sh;
                      else s_d.cfg_reg[7:0] = s_q.sh;
              endcase
              s_d.ptr = rpx_pkg::partner(s_q.ptr); // see RQ3
              s_d.drive_low = 1'b1;
              s_d.st = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_r && s_q.rd && !s_q.got_cmd) begin
            s_d.in_reg = s_q.pin_s1 ^ s_q.pol_reg; // see RQ9
          end
          if (scl_f) begin
            s_d.bitc = 3'h0;
            if (s_q.rd && !s_q.got_cmd) begin
              s_d.sh = reg_rd(s_q, s_q.ptr); // see RQ10
              s_d.drive_low = !s_d.sh[7];
              s_d.st = ST_RDATA;
            end else begin
              s_d.drive_low = 1'b0;
              s_d.st = s_q.got_cmd ? ST_WDATA : ST_CMD; // see RQ4
            end
          end
        end
        ST_RDATA: if (scl_f) begin
          if (s_q.bitc == rpx_pkg::BIT_LAST) begin
            s_d.drive_low = 1'b0;
            s_d.ptr = rpx_pkg::partner(s_q.ptr); // see RQ6
            s_d.st = ST_RACK;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.drive_low = !s_q.sh[6];
            s_d.bitc = s_q.bitc + 3'h1;
          end
        end
        ST_RACK: begin
          if (scl_r) begin
            s_d.in_reg = s_q.pin_s1 ^ s_q.pol_reg; // see RQ9
            s_d.got_cmd = s_q.sda_s[1]; // Nack marks the end
          end
          if (scl_f) begin
            s_d.bitc = 3'h0;
            if (s_q.got_cmd) begin
              s_d.st = ST_IDLE; // see RQ7
            end else begin
              s_d.sh = reg_rd(s_q, s_q.ptr);
              s_d.drive_low = !s_d.sh[7];
              s_d.st = ST_RDATA;
            end
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (por_rst) begin
      s_q <= '0; // see RQ12
      s_q.scl_s <= 2'b11;
      s_q.sda_s <= 2'b11;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.ptr <= rpx_pkg::PTR_RST;
      s_q.out_reg <= {2{rpx_pkg::OUT_RST}}; // see RQ15
      s_q.pol_reg <= {2{rpx_pkg::POL_RST}}; // see RQ16
      s_q.cfg_reg <= {2{rpx_pkg::CFG_RST}}; // see RQ17
      s_q.por_hold <= s_d.por_hold && !rst;
      // Supply synchronisers keep running so the hold can be released
      s_q.trip_s <= s_d.trip_s;
      s_q.rel_s <= s_d.rel_s;
    end else begin
      s_q <= s_d;
    end
  end

  assign port_out = s_q.out_reg;
  assign port_dir_in = s_q.cfg_reg; // see RQ17
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe_n = !s_q.drive_low;
endmodule : rpx_slave

/* File: verif/rpx_sva.sv */
// Checker on the two-wire link between the master and slave ends
`timescale 1ns/100ps
module rpx_sva (
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic scl_oe_n, // Master clock enable
  input wire logic sda_m_oe_n, // Master data enable
  input wire logic sda_s_oe_n, // Slave data enable
  input wire logic scl, // Resolved clock line
  input wire logic sda // Resolved data line
);
  localparam int START_MAX = 600;
  logic scl_oe_q;
  logic [3:0] hold_q;
  // Cycles since the master last moved the clock line
  always_ff @(posedge core_clk) begin
    scl_oe_q <= scl_oe_n;
    if (rst) begin
      hold_q <= 4'hF;
    end else if (scl_oe_n != scl_oe_q) begin
      hold_q <= 4'h0;
    end else if (hold_q != 4'hF) begin
      hold_q <= hold_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  rst_idle_a: assert property (disable iff (1'b0)
    rst |=> scl_oe_n && sda_m_oe_n && sda_s_oe_n) else $error("bus not released after reset");
  start_quiet_a: assert property (start_s |-> sda_s_oe_n ##1 sda_s_oe_n [*8])
    else $error("slave drives data around a start");
  stop_free_a: assert property (stop_s |=> sda_s_oe_n [*8])
    else $error("slave drives data after a stop");
  slave_change_a: assert property ($changed(sda_s_oe_n) |-> !scl && !$past(scl, 2))
    else $error("slave data moved while clock high");
  slave_owns_a: assert property (!sda_s_oe_n && scl |-> sda_m_oe_n)
    else $error("master drives data in a slave bit");
  scl_half_a: assert property ((scl_oe_n != scl_oe_q) |-> hold_q >= 4'h6)
    else $error("clock phase too short");
  start_low_a: assert property (start_s |-> ##[1:START_MAX] !scl)
    else $error("clock not pulled low after start");
  master_hold_a: assert property ($rose(scl) |-> $stable(sda_m_oe_n) [*4])
    else $error("master data moved at clock rise");
endmodule : rpx_sva

/* File: verif/tb_top.sv */
// Bench: APB-driven master end talking to the expander slave end
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] AW = {rpx_pkg::SLAVE_ADDR_DEF, 1'b0};
  localparam logic [7:0] AR = {rpx_pkg::SLAVE_ADDR_DEF, 1'b1};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic por_ok = 1'b1;
  logic por_trip = 1'b0;
  logic [15:0] port_in = 16'hC35A;
  logic [15:0] port_out;
  logic [15:0] port_dir_in;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  rpx_if bus ();
  // Open-drain lines with pull-ups
  assign bus.scl = bus.scl_oe_n;
  assign bus.sda = bus.sda_m_oe_n & bus.sda_s_oe_n;
  rpx_slave rpx_slave_i (.core_clk(core_clk), .rst(rst), .power_on_release_level(por_ok),
    .power_off_trip_level(por_trip), .slave_addr(rpx_pkg::SLAVE_ADDR_DEF),
    .port_in(port_in), .port_out(port_out), .port_dir_in(port_dir_in), .bus(bus));
  rpx_master rpx_master_i (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus));
  rpx_sva rpx_sva_i (.core_clk(core_clk), .rst(rst), .scl_oe_n(bus.scl_oe_n),
    .sda_m_oe_n(bus.sda_m_oe_n), .sda_s_oe_n(bus.sda_s_oe_n), .scl(bus.scl), .sda(bus.sda));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic cmd(input logic [2:0] c);
    int n;
    n = 0;
    apb(1'b1, rpx_pkg::A_CMD, {29'h0, c});
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0 && n < 9000) begin
      apb(1'b0, rpx_pkg::A_STAT, 32'h0000_0000);
      n++;
    end
  endtask : cmd
  task automatic wbyte(input logic [7:0] b, input logic nack);
    apb(1'b1, rpx_pkg::A_TXD, {24'h00_0000, b});
    cmd(rpx_pkg::C_WRITE);
    chk({15'h0000, rd[1]}, {15'h0000, nack});
  endtask : wbyte
  task automatic rbyte(input logic last, input logic [7:0] exp);
    cmd(last ? rpx_pkg::C_READ_NACK : rpx_pkg::C_READ_ACK);
    apb(1'b0, rpx_pkg::A_RXD, 32'h0000_0000);
    chk(rd[15:0], {8'h00, exp});
  endtask : rbyte
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(port_out, 16'hFFFF);
    chk(port_dir_in, 16'hFFFF);
    apb(1'b0, rpx_pkg::A_ADDR, 32'h0000_0000);
    chk(rd[15:0], 16'h0000);
    $display("test reset done");
    cmd(rpx_pkg::C_START);
    wbyte(AW, 1'b0);
    wbyte(8'h03, 1'b0);
    wbyte(8'hA5, 1'b0);
    wbyte(8'h3C, 1'b0);
    cmd(rpx_pkg::C_STOP);
    chk(port_out, 16'hA53C);
    cmd(rpx_pkg::C_START);
    wbyte(AW, 1'b0);
    wbyte(8'h04, 1'b0);
    wbyte(8'h0F, 1'b0);
    cmd(rpx_pkg::C_STOP);
    $display("test pair write done");
    cmd(rpx_pkg::C_START);
    wbyte(AW, 1'b0);
    wbyte(8'h01, 1'b0);
    cmd(rpx_pkg::C_START);
    wbyte(AR, 1'b0);
    rbyte(1'b0, 8'hC3);
    rbyte(1'b1, 8'h55);
    cmd(rpx_pkg::C_STOP);
    port_in <= 16'h96C3;
    cmd(rpx_pkg::C_START);
    wbyte(AR, 1'b0);
    rbyte(1'b1, 8'h96);
    cmd(rpx_pkg::C_STOP);
    $display("test pair read done");
    cmd(rpx_pkg::C_START);
    wbyte({~rpx_pkg::SLAVE_ADDR_DEF, 1'b0}, 1'b1);
    cmd(rpx_pkg::C_STOP);
    $display("test foreign address done");
    por_trip <= 1'b1;
    por_ok <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(port_out, 16'hFFFF);
    por_trip <= 1'b0;
    por_ok <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(port_out, 16'hFFFF);
    $display("test power cycle done");
    final_report();
  end
endmodule : tb_top
